/* File: design/pll_synth_pkg.sv */
// Package: constants shared by the synthesizer device end and its serial-load controller end.
// Assumes both ends run on one 10 MHz system clock.
package pll_synth_pkg;
    localparam int REF_WORD_LEN = 16;
    localparam int SWL_WORD_LEN = 19;
    localparam int REF_DIV_W = 14;
    localparam int MAIN_W = 11;
    localparam int SWALLOW_W = 7;
    localparam int RATIO_BIT_POS = 15;
    localparam int SELECT_BIT_POS = 0;
    localparam logic [7:0] RATIO_LOW = 8'h40;
    localparam logic [7:0] RATIO_HIGH = 8'h80;
    localparam logic [15:0] REF_WORD_RESET = 16'h0000;
    localparam logic [18:0] SWL_WORD_RESET = 19'h00000;
    localparam int SERIAL_HALF_CYCLES = 4;
    localparam logic [7:0] CTL_CTRL_OFS = 8'h00;
    localparam logic [7:0] CTL_REF_OFS = 8'h04;
    localparam logic [7:0] CTL_SWL_OFS = 8'h08;
    localparam logic [7:0] CTL_STATUS_OFS = 8'h0c;
endpackage

/* File: design/pll_serial_if.sv */
// Interface: three-wire serial load port: serial tick, serial data and load strobe.
// Assumes the testbench drives one end from each modport.
`timescale 1ns/1ps
`default_nettype none
interface pll_serial_if;
    logic serial_tick;
    logic serial_data;
    logic load_strobe;
    modport device (input serial_tick, input serial_data, input load_strobe);
    modport host (output serial_tick, output serial_data, output load_strobe);
endinterface
`default_nettype wire

/* File: design/pll_synth_device.sv */
// Device end: serial shift register, two divider latches, dividers, phase detector.
// Assumes reference and VCO inputs are slow enough to be sampled by I_CLK.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pll_synth_device (
    input  wire logic    I_CLK,
    input  wire logic    I_RST,
    input  wire logic    I_CE,
    pll_serial_if.device SER,
    input  wire logic    I_REFERENCE_INPUT,
    input  wire logic    I_VCO_INPUT,
    input  wire logic    I_POWER_SAVE_N,
    input  wire logic    I_PHASE_POLARITY_SELECT,
    output logic         O_PUMP_A,
    output logic         O_PUMP_A_OE,
    output logic         O_PUMP_B,
    output logic         O_PUMP_B_OE,
    output logic         O_REF_PHASE,
    output logic         O_PROG_PHASE,
    output logic         O_MONITOR,
    output logic [15:0]  O_REF_WORD,
    output logic [18:0]  O_SWL_WORD
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: every pin passes two flops
    logic [6:0] s1_reg;
    logic [6:0] s2_reg;
    logic [6:0] s3_reg;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            s1_reg <= 7'h60;
            s2_reg <= 7'h60;
            s3_reg <= 7'h60;
        end else if (I_CE) begin
            s1_reg <= {I_POWER_SAVE_N, I_PHASE_POLARITY_SELECT, SER.serial_tick, SER.serial_data,
                       SER.load_strobe, I_REFERENCE_INPUT, I_VCO_INPUT};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    logic awake;
    logic pol_high;
    logic tick_rise;
    logic sdata;
    logic strobe;
    logic strobe_rise;
    logic ref_rise;
    logic vco_rise;
    assign awake = s2_reg[6];
    assign pol_high = s2_reg[5];
    assign tick_rise = s2_reg[4] & ~s3_reg[4];
    assign sdata = s2_reg[3];
    assign strobe = s2_reg[2];
    assign strobe_rise = s2_reg[2] & ~s3_reg[2];
    assign ref_rise = s2_reg[1] & ~s3_reg[1];
    assign vco_rise = s2_reg[0] & ~s3_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Shift register and latches
    logic [18:0] shift_reg;
    logic [5:0]  count_reg;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            shift_reg <= 19'h00000;
            count_reg <= 6'h00;
        end else if (I_CE && awake) begin
            if (strobe_rise) begin
                count_reg <= 6'h00;
            end else if (tick_rise) begin
                shift_reg <= {shift_reg[17:0], sdata};
                if (count_reg != 6'h3f) begin
                    count_reg <= count_reg + 6'h01;
                end
            end
        end
    end
    // Select bit is the last bit shifted in
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_REF_WORD <= pll_synth_pkg::REF_WORD_RESET;
            O_SWL_WORD <= pll_synth_pkg::SWL_WORD_RESET;
        end else if (I_CE && awake && strobe_rise) begin
            if (shift_reg[pll_synth_pkg::SELECT_BIT_POS] && count_reg >= 6'(pll_synth_pkg::REF_WORD_LEN)) begin
                O_REF_WORD <= shift_reg[15:0];
            end else if (!shift_reg[pll_synth_pkg::SELECT_BIT_POS]
                         && count_reg >= 6'(pll_synth_pkg::SWL_WORD_LEN)) begin
                O_SWL_WORD <= shift_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dividers
    logic [13:0] ref_div;
    logic [10:0] main_val;
    logic [6:0]  swallow_val;
    logic        ratio64;
    assign ref_div = O_REF_WORD[14:1];
    assign ratio64 = O_REF_WORD[pll_synth_pkg::RATIO_BIT_POS];
    assign main_val = O_SWL_WORD[18:8];
    assign swallow_val = O_SWL_WORD[7:1];

    logic [13:0] rcnt_reg;
    logic        ref_tick_reg;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rcnt_reg <= 14'h0000;
            ref_tick_reg <= 1'b0;
        end else if (I_CE && awake) begin
            ref_tick_reg <= 1'b0;
            if (ref_rise) begin
                if (rcnt_reg + 14'h0001 >= ref_div) begin
                    rcnt_reg <= 14'h0000;
                    ref_tick_reg <= 1'b1;
                end else begin
                    rcnt_reg <= rcnt_reg + 14'h0001;
                end
            end
        end
    end

    // Pulse swallow: modulus N+1 for swallow_val cycles, N for the rest
    logic [7:0]  pre_reg;
    logic [10:0] mcnt_reg;
    logic [6:0]  scnt_reg;
    logic        prog_tick_reg;
    logic [7:0]  modulus;
    assign modulus = (ratio64 ? pll_synth_pkg::RATIO_LOW : pll_synth_pkg::RATIO_HIGH)
                     + {7'h00, (scnt_reg < swallow_val)};
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            pre_reg <= 8'h00;
            mcnt_reg <= 11'h000;
            scnt_reg <= 7'h00;
            prog_tick_reg <= 1'b0;
        end else if (I_CE && awake) begin
            prog_tick_reg <= 1'b0;
            if (vco_rise) begin
                if (pre_reg + 8'h01 >= modulus) begin
                    pre_reg <= 8'h00;
                    if (scnt_reg < swallow_val) begin
                        scnt_reg <= scnt_reg + 7'h01;
                    end
                    if (mcnt_reg + 11'h001 >= main_val) begin
                        mcnt_reg <= 11'h000;
                        scnt_reg <= 7'h00;
                        prog_tick_reg <= 1'b1;
                    end else begin
                        mcnt_reg <= mcnt_reg + 11'h001;
                    end
                end else begin
                    pre_reg <= pre_reg + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase-frequency detector: up = reference leads, down = program leads
    logic up_reg;
    logic down_reg;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            up_reg <= 1'b0;
            down_reg <= 1'b0;
        end else if (I_CE) begin
            if (!awake) begin
                up_reg <= 1'b0;
                down_reg <= 1'b0;
            end else if ((up_reg | ref_tick_reg) && (down_reg | prog_tick_reg)) begin
                up_reg <= 1'b0;
                down_reg <= 1'b0;
            end else begin
                up_reg <= up_reg | ref_tick_reg;
                down_reg <= down_reg | prog_tick_reg;
            end
        end
    end

    logic pump_lvl;
    logic active;
    assign active = up_reg ^ down_reg;
    assign pump_lvl = up_reg ~^ pol_high;
    // Registered outputs; pin buffers are off in power save
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_PUMP_A <= 1'b0;
            O_PUMP_A_OE <= 1'b0;
            O_PUMP_B <= 1'b0;
            O_PUMP_B_OE <= 1'b0;
            O_REF_PHASE <= 1'b0;
            O_PROG_PHASE <= 1'b1;
            O_MONITOR <= 1'b0;
        end else if (I_CE) begin
            O_PUMP_A <= pump_lvl;
            O_PUMP_A_OE <= awake & active;
            O_PUMP_B <= pump_lvl;
            O_PUMP_B_OE <= awake & active & strobe;
            O_REF_PHASE <= active ? ~pump_lvl : 1'b0;
            O_PROG_PHASE <= active ? ~pump_lvl : 1'b1;
            O_MONITOR <= pol_high ? ref_tick_reg : prog_tick_reg;
        end
    end
endmodule
`default_nettype wire

/* File: design/pll_synth_host.sv */
// Host end: AHB-Lite slave registers that order serial word loads to the device.
// Assumes one AHB-Lite master on I_CLK; serial tick made by dividing I_CLK.
`timescale 1ns/1ps
`default_nettype none
module pll_synth_host (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_CE,
    pll_serial_if.host       SER,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic [31:0]      O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP
);
    typedef enum {IDLE, SHIFT_LO, SHIFT_HI, STROBE, DONE} state_type;
    state_type   state_reg;
    logic [15:0] ref_reg;
    logic [18:0] swl_reg;
    logic [18:0] sh_reg;
    logic [4:0]  bits_reg;
    logic [3:0]  tim_reg;
    logic        wr_reg;
    logic [7:0]  addr_reg;
    logic        start;
    logic        start_ref;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one-cycle address capture, data in the next cycle
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            wr_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (I_CE) begin
            wr_reg <= I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE;
            addr_reg <= I_HADDR[7:0];
        end
    end
    assign start = I_CE && wr_reg && addr_reg == pll_synth_pkg::CTL_CTRL_OFS && state_reg == IDLE;
    assign start_ref = I_HWDATA[0];
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            ref_reg <= pll_synth_pkg::REF_WORD_RESET;
            swl_reg <= pll_synth_pkg::SWL_WORD_RESET;
        end else if (I_CE && wr_reg) begin
            if (addr_reg == pll_synth_pkg::CTL_REF_OFS) begin
                ref_reg <= I_HWDATA[15:0];
            end else if (addr_reg == pll_synth_pkg::CTL_SWL_OFS) begin
                swl_reg <= I_HWDATA[18:0];
            end
        end
    end
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_HRDATA <= 32'h00000000;
        end else if (I_CE) begin
            if (I_HADDR[7:0] == pll_synth_pkg::CTL_REF_OFS) begin
                O_HRDATA <= {16'h0000, ref_reg};
            end else if (I_HADDR[7:0] == pll_synth_pkg::CTL_SWL_OFS) begin
                O_HRDATA <= {13'h0000, swl_reg};
            end else if (I_HADDR[7:0] == pll_synth_pkg::CTL_STATUS_OFS) begin
                O_HRDATA <= {31'h00000000, state_reg != IDLE};
            end else begin
                O_HRDATA <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial sequencer: word sent MSB first, select bit forced into its bit 0
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_reg <= IDLE;
            sh_reg <= 19'h00000;
            bits_reg <= 5'h00;
            tim_reg <= 4'h0;
        end else if (I_CE) begin
            case (state_reg)
                IDLE: begin
                    if (start) begin
                        // Ref word left-aligned so its ratio bit goes first
                        sh_reg <= start_ref ? {ref_reg[15:1], 1'b1, 3'h0} : {swl_reg[18:1], 1'b0};
                        bits_reg <= start_ref ? 5'(pll_synth_pkg::REF_WORD_LEN)
                                              : 5'(pll_synth_pkg::SWL_WORD_LEN);
                        tim_reg <= 4'h0;
                        state_reg <= SHIFT_LO;
                    end
                end
                SHIFT_LO: begin
                    tim_reg <= tim_reg + 4'h1;
                    if (tim_reg == 4'(pll_synth_pkg::SERIAL_HALF_CYCLES - 1)) begin
                        tim_reg <= 4'h0;
                        state_reg <= SHIFT_HI;
                    end
                end
                SHIFT_HI: begin
                    tim_reg <= tim_reg + 4'h1;
                    if (tim_reg == 4'(pll_synth_pkg::SERIAL_HALF_CYCLES - 1)) begin
                        tim_reg <= 4'h0;
                        sh_reg <= {sh_reg[17:0], 1'b0};
                        bits_reg <= bits_reg - 5'h01;
                        state_reg <= (bits_reg == 5'h01) ? STROBE : SHIFT_LO;
                    end
                end
                STROBE: begin
                    tim_reg <= tim_reg + 4'h1;
                    if (tim_reg == 4'(pll_synth_pkg::SERIAL_HALF_CYCLES - 1)) begin
                        tim_reg <= 4'h0;
                        state_reg <= DONE;
                    end
                end
                DONE: begin
                    state_reg <= IDLE;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end
    // Data held through the whole tick period so the device samples it safely
    assign SER.serial_data = sh_reg[18];
    assign SER.serial_tick = (state_reg == SHIFT_HI);
    assign SER.load_strobe = (state_reg == STROBE);
endmodule
`default_nettype wire

/* File: tb/pll_synth_props.sv */
// Checker: serial port timing and the device's pump, phase and latch outputs.
// Assumes it sits beside the serial interface in tb, all on one I_CLK domain.
`timescale 1ns/1ps
`default_nettype none
module pll_synth_props (
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        serial_tick,
    input wire logic        serial_data,
    input wire logic        load_strobe,
    input wire logic        I_POWER_SAVE_N,
    input wire logic        O_PUMP_A,
    input wire logic        O_PUMP_A_OE,
    input wire logic        O_PUMP_B,
    input wire logic        O_PUMP_B_OE,
    input wire logic        O_REF_PHASE,
    input wire logic        O_PROG_PHASE,
    input wire logic [15:0] O_REF_WORD,
    input wire logic [18:0] O_SWL_WORD
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    ////////////////////////////////////////////////////////////////////////////////
    a_tick_high_len: assert property ($rose(serial_tick) |-> serial_tick[*4] ##1 !serial_tick)
        else $error("serial tick high phase not four cycles");
    a_data_steady: assert property (serial_tick |-> $stable(serial_data))
        else $error("serial data moved while tick high");
    a_strobe_len: assert property ($rose(load_strobe) |-> load_strobe[*4] ##1 !load_strobe)
        else $error("load strobe not four cycles");
    a_strobe_tick_low: assert property (load_strobe |-> !serial_tick)
        else $error("tick high during load strobe");
    // Six quiet cycles cover the two-flop sync plus the output register
    a_pump_b_float: assert property ((!load_strobe)[*6] |-> !O_PUMP_B_OE)
        else $error("pump b driven with strobe low");
    a_pump_b_copy: assert property (O_PUMP_B_OE |-> O_PUMP_A_OE && O_PUMP_B == O_PUMP_A)
        else $error("pump b differs from pump a");
    a_save_float: assert property ((!I_POWER_SAVE_N)[*6] |-> !O_PUMP_A_OE && !O_PUMP_B_OE)
        else $error("pumps driven in power save");
    a_save_hold: assert property ((!I_POWER_SAVE_N)[*8] |=> $stable(O_REF_WORD) && $stable(O_SWL_WORD))
        else $error("latch changed in power save");
    a_phase_pair: assert property (O_PUMP_A_OE |-> O_REF_PHASE == O_PROG_PHASE && O_PUMP_A != O_REF_PHASE)
        else $error("pump and phase outputs disagree");
    // Gated by the pin: entering power save leaves one cycle of stale phase levels
    a_phase_idle: assert property (I_POWER_SAVE_N && !O_PUMP_A_OE |-> !O_REF_PHASE && O_PROG_PHASE)
        else $error("phase outputs not idle with pumps floating");
    a_ref_select: assert property ($changed(O_REF_WORD) |-> O_REF_WORD[0])
        else $error("reference latch loaded without select high");
    a_swl_select: assert property ($changed(O_SWL_WORD) |-> !O_SWL_WORD[0])
        else $error("swallow latch loaded without select low");
    c_strobe: cover property ($rose(load_strobe));
    c_pump_b: cover property (O_PUMP_B_OE);
    c_save: cover property ((!I_POWER_SAVE_N)[*8]);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Testbench: host and device joined over the serial interface, host driven over AHB-Lite.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LIMIT = 60000;
    logic        clk, rst, hsel, hwrite, hready, hresp, ref_in, vco_in, ps_n, pol, meas, want;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic        pa, pa_oe, pb, pb_oe, rph, pph, mon;
    logic [15:0] ref_word, exp_ref, lfsr;
    logic [18:0] swl_word, exp_swl;
    int          failures, checks_done, cycles, ref_half, vco_half, rc, vc;
    int          ref_edges, vco_edges, mon_cnt, up_cnt, dn_cnt;
    pll_serial_if ser ();
    ////////////////////////////////////////////////////////////////////////////////
    pll_synth_host i_pll_synth_host (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .SER(ser), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp));
    pll_synth_device i_pll_synth_device (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .SER(ser),
        .I_REFERENCE_INPUT(ref_in), .I_VCO_INPUT(vco_in), .I_POWER_SAVE_N(ps_n), .I_PHASE_POLARITY_SELECT(pol),
        .O_PUMP_A(pa), .O_PUMP_A_OE(pa_oe), .O_PUMP_B(pb), .O_PUMP_B_OE(pb_oe), .O_REF_PHASE(rph),
        .O_PROG_PHASE(pph), .O_MONITOR(mon), .O_REF_WORD(ref_word), .O_SWL_WORD(swl_word));
    pll_synth_props i_pll_synth_props (.I_CLK(clk), .I_RST(rst), .serial_tick(ser.serial_tick),
        .serial_data(ser.serial_data), .load_strobe(ser.load_strobe), .I_POWER_SAVE_N(ps_n), .O_PUMP_A(pa),
        .O_PUMP_A_OE(pa_oe), .O_PUMP_B(pb), .O_PUMP_B_OE(pb_oe), .O_REF_PHASE(rph), .O_PROG_PHASE(pph),
        .O_REF_WORD(ref_word), .O_SWL_WORD(swl_word));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Reference and VCO are slow square waves so the device can sample them
    always @(posedge clk) begin
        rc <= (rc + 1) % ref_half;
        vc <= (vc + 1) % vco_half;
        if (rc == ref_half - 1) ref_in <= ~ref_in;
        if (vc == vco_half - 1) vco_in <= ~vco_in;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            end_of_test();
        end
    end
    always @(posedge clk) begin
        if (meas) begin
            ref_edges <= ref_edges + ((rc == ref_half - 1 && !ref_in) ? 1 : 0);
            vco_edges <= vco_edges + ((vc == vco_half - 1 && !vco_in) ? 1 : 0);
            mon_cnt <= mon_cnt + ((mon === 1'b1) ? 1 : 0);
            up_cnt <= up_cnt + ((pa_oe === 1'b1 && pa === want) ? 1 : 0);
            dn_cnt <= dn_cnt + ((pa_oe === 1'b1 && pa !== want) ? 1 : 0);
        end else begin
            ref_edges <= 0;
            vco_edges <= 0;
            mon_cnt <= 0;
            up_cnt <= 0;
            dn_cnt <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Counts are taken over a window of arbitrary phase, so one off is allowed
    task automatic check_near(input int got, input int exp);
        checks_done++;
        if (got < exp - 1 || got > exp + 1) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Model: a word lands in its latch with the select bit forced, unless power save is on
    task automatic load(input logic sel, input logic [18:0] w);
        ahb(1'b1, sel ? pll_synth_pkg::CTL_REF_OFS : pll_synth_pkg::CTL_SWL_OFS, {13'h0, w}, rdv);
        ahb(1'b1, pll_synth_pkg::CTL_CTRL_OFS, {31'h0, sel}, rdv);
        rdv = 32'h1;
        while (rdv[0] !== 1'b0) ahb(1'b0, pll_synth_pkg::CTL_STATUS_OFS, 32'h0, rdv);
        ahb(1'b0, sel ? pll_synth_pkg::CTL_REF_OFS : pll_synth_pkg::CTL_SWL_OFS, 32'h0, rdv);
        check_word(rdv, sel ? {16'h0, w[15:0]} : {13'h0, w});
        repeat (8) @(posedge clk);
        if (ps_n && sel) exp_ref = w[15:0] | 16'h0001;
        if (ps_n && !sel) exp_swl = w & 19'h7fffe;
        check_word({16'h0, ref_word}, {16'h0, exp_ref});
        check_word({13'h0, swl_word}, {13'h0, exp_swl});
    endtask
    task automatic pfd_run(input logic p, input int rh, input logic ratio);
        pol <= p;
        ref_half <= rh;
        want <= p ~^ (rh == 4);
        load(1'b1, {3'h0, ratio, 14'h0004, 1'b1});
        meas <= 1'b1;
        repeat (5000) @(posedge clk);
        meas <= 1'b0;
        @(posedge clk);
        check_near(mon_cnt, p ? ref_edges / 4 : vco_edges / (ratio ? 129 : 257));
        check_word({31'h0, up_cnt > dn_cnt}, 32'h1);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
        ref_in = 1'b0; vco_in = 1'b0; ps_n = 1'b1; pol = 1'b1; meas = 1'b0; want = 1'b1;
        ref_half = 4; vco_half = 3; rc = 0; vc = 0; cycles = 0; failures = 0; checks_done = 0;
        lfsr = 16'h0008; exp_ref = 16'h0; exp_swl = 19'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_word({10'h0, swl_word, ref_word[0], pa_oe, pb_oe}, 32'h0);
        ahb(1'b0, 8'h10, 32'h0, rdv);
        check_word(rdv, 32'h0);
        check_word({31'h0, hresp}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            load(1'b1, {3'h0, lfsr[15], lfsr[13:0], 1'b0});
            lfsr = lfsr_next(lfsr);
            load(1'b0, {1'b1, lfsr[9:0], lfsr[15:9], 1'b1});
        end
        // A load attempted in power save must leave both latches alone
        ps_n <= 1'b0;
        repeat (8) @(posedge clk);
        load(1'b0, {11'h7ff, 7'h55, 1'b0});
        check_word({30'h0, pa_oe, pb_oe}, 32'h0);
        ps_n <= 1'b1;
        load(1'b0, {11'h002, 7'h01, 1'b0});
        pfd_run(1'b1, 4, 1'b1);
        pfd_run(1'b1, 300, 1'b0);
        pfd_run(1'b0, 4, 1'b0);
        pfd_run(1'b0, 300, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
